/* include/arr_pkg.sv */
// package: constants and state type for the accumulator round/rotate slice
package arr_pkg;
    localparam int ACC_W = 56;
    localparam int UPPER_MSB = 47;
    localparam int UPPER_LSB = 24;
    localparam logic [1:0] SCALE_NONE = 2'h0;
    localparam logic [1:0] SCALE_DOWN = 2'h1;
    localparam logic [1:0] SCALE_UP = 2'h2;
    localparam logic [5:0] POS24_NONE = 6'h17;
    localparam logic [5:0] POS24_DOWN = 6'h18;
    localparam logic [5:0] POS24_UP = 6'h16;
    localparam logic [5:0] POS16_NONE = 6'h1f;
    localparam logic [5:0] POS16_DOWN = 6'h20;
    localparam logic [5:0] POS16_UP = 6'h1e;
    localparam logic [55:0] ACC_RESET = 56'h0;
    localparam logic [2:0] OP_IDLE = 3'h0;
    localparam logic [2:0] OP_RND = 3'h1;
    localparam logic [2:0] OP_ROL = 3'h2;
    localparam logic [2:0] OP_ROR = 3'h4;

    typedef struct packed {
        logic [55:0] acc_a;
        logic [55:0] acc_b;
        logic flag_n;
        logic flag_z;
        logic flag_v;
        logic flag_c;
        logic done;
    } arr_state_s;
endpackage

/* test/arr_core_tb.sv */
// self-checking bench for the accumulator round and rotate slice
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, SRST = 1'b1, ROUND_ACCUMULATOR_OP = 1'b0, ROTATE_LEFT_OP = 1'b0, ROTATE_RIGHT_OP = 1'b0;
    logic DEST_SEL_B = 1'b0, SCALE_SEL_LOW = 1'b0, SCALE_SEL_HIGH = 1'b0, ROUNDING_KIND_SELECT = 1'b0;
    logic SIXTEEN_BIT_MODE = 1'b0, ACC_LOAD_A = 1'b0, ACC_LOAD_B = 1'b0, CARRY_LOAD = 1'b0, CARRY_LOAD_VALUE = 1'b0;
    logic [55:0] ACC_LOAD_DATA = 56'h0, ACC_A, ACC_B;
    logic FLAG_N, FLAG_Z, FLAG_V, FLAG_C, OP_DONE;
    int err_count = 0, checks_done = 0, cyc = 0;
    arr_core dut (.CLK(CLK), .SRST(SRST), .ROUND_ACCUMULATOR_OP(ROUND_ACCUMULATOR_OP),
        .ROTATE_LEFT_OP(ROTATE_LEFT_OP), .ROTATE_RIGHT_OP(ROTATE_RIGHT_OP), .DEST_SEL_B(DEST_SEL_B),
        .SCALE_SEL_LOW(SCALE_SEL_LOW), .SCALE_SEL_HIGH(SCALE_SEL_HIGH), .ROUNDING_KIND_SELECT(ROUNDING_KIND_SELECT),
        .SIXTEEN_BIT_MODE(SIXTEEN_BIT_MODE), .ACC_LOAD_A(ACC_LOAD_A), .ACC_LOAD_B(ACC_LOAD_B),
        .ACC_LOAD_DATA(ACC_LOAD_DATA), .CARRY_LOAD(CARRY_LOAD), .CARRY_LOAD_VALUE(CARRY_LOAD_VALUE),
        .ACC_A(ACC_A), .ACC_B(ACC_B), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .FLAG_V(FLAG_V), .FLAG_C(FLAG_C),
        .OP_DONE(OP_DONE));
    always #5 CLK = ~CLK;
    // hang guard: all tests need well under a thousand cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc >= 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // expected rounding worked out independently of the design's rounding unit
    function automatic logic [55:0] rnd_model(input logic [55:0] v, input int p, input logic conv);
        logic [55:0] s, low;
        low = (56'h1 << (p + 1)) - 56'h1;
        s = v + (56'h1 << p);
        if (conv && (s & low) == 56'h0) s[p + 1] = 1'b0;
        return s & ~low;
    endfunction
    task automatic load(input logic dst_b, input logic [55:0] d, input logic c);
        @(negedge CLK);
        ACC_LOAD_A = !dst_b;
        ACC_LOAD_B = dst_b;
        ACC_LOAD_DATA = d;
        CARRY_LOAD = 1'b1;
        CARRY_LOAD_VALUE = c;
        @(negedge CLK);
        {ACC_LOAD_A, ACC_LOAD_B, CARRY_LOAD} = 3'h0;
    endtask
    // k: [1:0] scaling, [2] sixteen-bit, [3] two's complement; tie puts an exact half below the cut
    task automatic round_case(input int k, input logic tie);
        logic [55:0] v, other, got, rv;
        logic dst_b;
        int p;
        dst_b = k[0] ^ k[2];
        p = k[2] ? 31 : 23;
        if (k[1:0] == 1) p = p + 1;
        if (k[1:0] == 2) p = p - 1;
        v = 56'h0a5a5a5a5a5a5a;
        if (tie) v = (v & ~((56'h1 << (p + 2)) - 56'h1)) | (56'h1 << p);
        load(dst_b, v, 1'b1);
        other = dst_b ? ACC_A : ACC_B;
        @(negedge CLK);
        {SCALE_SEL_HIGH, SCALE_SEL_LOW} = k[1:0];
        SIXTEEN_BIT_MODE = k[2];
        ROUNDING_KIND_SELECT = k[3];
        DEST_SEL_B = dst_b;
        ROUND_ACCUMULATOR_OP = 1'b1;
        @(negedge CLK);
        ROUND_ACCUMULATOR_OP = 1'b0;
        rv = rnd_model(v, p, !k[3]);
        got = dst_b ? ACC_B : ACC_A;
        chk(got, rv, "rounded");
        chk(dst_b ? ACC_A : ACC_B, other, "other accumulator");
        chk({55'h0, OP_DONE}, 56'h1, "done pulse");
        $display("round case %0d tie %0d done", k, tie);
    endtask
    // both: raise both rotate strobes, the left one must win
    task automatic rot_case(input logic left, input logic dst_b, input logic both);
        logic [55:0] old, exp;
        logic ec;
        logic [3:0] ef;
        old = dst_b ? ACC_B : ACC_A;
        exp = old;
        if (left) exp[47:24] = {old[46:24], FLAG_C};
        else exp[47:24] = {FLAG_C, old[47:25]};
        ec = left ? old[47] : old[24];
        ef = {ec, exp[47], exp[47:24] == 24'h0, 1'b0};
        @(negedge CLK);
        DEST_SEL_B = dst_b;
        ROTATE_LEFT_OP = left;
        ROTATE_RIGHT_OP = !left || both;
        @(negedge CLK);
        {ROTATE_LEFT_OP, ROTATE_RIGHT_OP} = 2'h0;
        chk(dst_b ? ACC_B : ACC_A, exp, "rotated accumulator");
        chk({52'h0, FLAG_C, FLAG_N, FLAG_Z, FLAG_V}, {52'h0, ef}, "flags C N Z V");
        chk({55'h0, OP_DONE}, 56'h1, "done pulse");
        @(negedge CLK);
        chk({55'h0, OP_DONE}, 56'h0, "done drops");
        $display("rotate case done");
    endtask
    // all state must read zero once reset has been seen
    task automatic chk_reset_state();
        chk(ACC_A, 56'h0, "reset acc A");
        chk(ACC_B, 56'h0, "reset acc B");
        chk({51'h0, FLAG_N, FLAG_Z, FLAG_V, FLAG_C, OP_DONE}, 56'h0, "reset flags and done");
    endtask
    // rotate left then right on consecutive edges: the second uses the first's result
    task automatic back_to_back_case();
        load(1'b0, 56'h5ac00001123456, 1'b0);
        @(negedge CLK);
        DEST_SEL_B = 1'b0;
        ROTATE_LEFT_OP = 1'b1;
        @(negedge CLK);
        ROTATE_LEFT_OP = 1'b0;
        ROTATE_RIGHT_OP = 1'b1;
        chk(ACC_A, 56'h5a800002123456, "first of pair");
        @(negedge CLK);
        ROTATE_RIGHT_OP = 1'b0;
        chk(ACC_A, 56'h5ac00001123456, "pair restores word");
        chk({52'h0, FLAG_C, FLAG_N, FLAG_Z, FLAG_V}, {52'h0, 4'h4}, "pair flags C N Z V");
        $display("back to back test done");
    endtask
    // reset in mid-run while both accumulators and carry hold nonzero values
    task automatic reset_case();
        load(1'b1, 56'h00123456789abc, 1'b1);
        @(negedge CLK);
        SRST = 1'b1;
        repeat (2) @(negedge CLK);
        SRST = 1'b0;
        chk_reset_state();
        $display("reset test done");
    endtask
    initial begin
        repeat (6) @(negedge CLK);
        SRST = 1'b0;
        chk_reset_state();
        for (int k = 0; k < 16; k++) begin
            round_case(k, 1'b1);
            round_case(k, 1'b0);
        end
        $display("round tests done");
        load(1'b0, 56'h12800001abcdef, 1'b1);
        for (int i = 0; i < 4; i++) rot_case(i < 2, 1'b0, i == 1);
        load(1'b1, 56'hff000000ffffff, 1'b0);
        rot_case(1'b1, 1'b1, 1'b0);
        rot_case(1'b0, 1'b1, 1'b0);
        load(1'b1, 56'h00800000000000, 1'b0);
        rot_case(1'b1, 1'b1, 1'b0);
        $display("rotate tests done");
        back_to_back_case();
        reset_case();
        report_and_stop();
    end
endmodule

/* verilog/arr_core.sv */
// accumulator round and rotate-through-carry datapath slice
// Functional notes
// RULE_01: round reads whole 56-bit A or B and writes back same accumulator
// RULE_02: rounding-kind bit picks convergent or two's complement rounding
// RULE_03: kept/discarded split follows the two scaling bits
// RULE_04: 24-bit mode positions: 23 none, 24 down, 22 up
// RULE_05: sixteen-bit mode positions: 31 none, 32 down, 30 up
// RULE_06: rounding constant is a single one at the rounding position
// RULE_07: convergent: zero low bits after add clears bit above position
// RULE_08: final step clears all bits at and below rounding position
// RULE_09: rotate left bits 47-24 through carry, others kept
// RULE_10: rotate right bits 47-24 through carry, others kept
// RULE_11: rotates set N from bit 47, Z from 47-24 zero, clear V
// RULE_12: one select bit picks A or B; scaling 11 means no scaling
module arr_core (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic ROUND_ACCUMULATOR_OP,
    input wire logic ROTATE_LEFT_OP,
    input wire logic ROTATE_RIGHT_OP,
    input wire logic DEST_SEL_B,
    input wire logic SCALE_SEL_LOW,
    input wire logic SCALE_SEL_HIGH,
    input wire logic ROUNDING_KIND_SELECT,
    input wire logic SIXTEEN_BIT_MODE,
    input wire logic ACC_LOAD_A,
    input wire logic ACC_LOAD_B,
    input wire logic [55:0] ACC_LOAD_DATA,
    input wire logic CARRY_LOAD,
    input wire logic CARRY_LOAD_VALUE,
    output logic [55:0] ACC_A,
    output logic [55:0] ACC_B,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic FLAG_V,
    output logic FLAG_C,
    output logic OP_DONE
);
    arr_pkg::arr_state_s st_q;
    arr_pkg::arr_state_s st_d;
    logic [55:0] src;
    logic [55:0] rounded;
    logic [5:0] round_pos;
    logic [23:0] rot_word;
    logic [2:0] op_sel;

    // rounding-kind bit high selects two's complement, low convergent
    arr_round_unit u_round (
        .value(src),
        .scale_sel({SCALE_SEL_HIGH, SCALE_SEL_LOW}), // RULE_03
        .sixteen_bit(SIXTEEN_BIT_MODE), // RULE_05
        .convergent(~ROUNDING_KIND_SELECT), // RULE_02
        .rounded(rounded),
        .round_pos(round_pos)
    );

    assign src = DEST_SEL_B ? st_q.acc_b : st_q.acc_a; // RULE_12
    // one op at a time; round wins over rotates if decode glitches
    assign op_sel = ROUND_ACCUMULATOR_OP ? arr_pkg::OP_RND :
                    ROTATE_LEFT_OP ? arr_pkg::OP_ROL :
                    ROTATE_RIGHT_OP ? arr_pkg::OP_ROR : arr_pkg::OP_IDLE;

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        rot_word = src[47:24];
        if (ACC_LOAD_A) begin
            st_d.acc_a = ACC_LOAD_DATA;
        end
        if (ACC_LOAD_B) begin
            st_d.acc_b = ACC_LOAD_DATA;
        end
        if (CARRY_LOAD) begin
            st_d.flag_c = CARRY_LOAD_VALUE;
        end
        unique case (op_sel)
            arr_pkg::OP_RND: begin
                if (DEST_SEL_B) begin
                    st_d.acc_b = rounded; // RULE_01
                end else begin
                    st_d.acc_a = rounded; // RULE_01
                end
                st_d.done = 1'b1;
            end
            arr_pkg::OP_ROL: begin
                rot_word = {src[46:24], st_q.flag_c}; // RULE_09
                st_d.flag_c = src[47]; // RULE_09
            end
            arr_pkg::OP_ROR: begin
                rot_word = {st_q.flag_c, src[47:25]}; // RULE_10
                st_d.flag_c = src[24]; // RULE_10
            end
            default: begin
            end
        endcase
        if (op_sel == arr_pkg::OP_ROL || op_sel == arr_pkg::OP_ROR) begin
            // only the upper word changes, extension and low word kept
            if (DEST_SEL_B) begin
                st_d.acc_b = {src[55:48], rot_word, src[23:0]};
            end else begin
                st_d.acc_a = {src[55:48], rot_word, src[23:0]};
            end
            st_d.flag_n = rot_word[23]; // RULE_11
            st_d.flag_z = (rot_word == 24'h0); // RULE_11
            st_d.flag_v = 1'b0; // RULE_11
            st_d.done = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_q <= '{acc_a: arr_pkg::ACC_RESET, acc_b: arr_pkg::ACC_RESET, default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign ACC_A = st_q.acc_a;
    assign ACC_B = st_q.acc_b;
    assign FLAG_N = st_q.flag_n;
    assign FLAG_Z = st_q.flag_z;
    assign FLAG_V = st_q.flag_v;
    assign FLAG_C = st_q.flag_c;
    assign OP_DONE = st_q.done;

    round_low_clear_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_08
        ROUND_ACCUMULATOR_OP && !DEST_SEL_B |=> ((ACC_A & ((56'h2 << $past(round_pos)) - 56'h1)) == 56'h0))
        else $error("round left low bits set");
    round_dest_b_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_01
        ROUND_ACCUMULATOR_OP && DEST_SEL_B && !ACC_LOAD_B |=> ACC_B == $past(rounded))
        else $error("round did not write B");
    pos_24_none_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_04
        !SIXTEEN_BIT_MODE && !SCALE_SEL_LOW |-> round_pos == (SCALE_SEL_HIGH ? 6'h16 : 6'h17))
        else $error("wrong 24-bit position");
    pos_16_down_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_05
        SIXTEEN_BIT_MODE && SCALE_SEL_LOW && !SCALE_SEL_HIGH |-> round_pos == 6'h20)
        else $error("wrong 16-bit position");
    scale_11_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_12
        SCALE_SEL_LOW && SCALE_SEL_HIGH |-> round_pos == (SIXTEEN_BIT_MODE ? 6'h1f : 6'h17))
        else $error("scale 11 not treated as none");
    twos_round_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_06
        ROUND_ACCUMULATOR_OP && ROUNDING_KIND_SELECT |->
        rounded == ((src + (56'h1 << round_pos)) & ~((56'h2 << round_pos) - 56'h1)))
        else $error("two's complement round mismatch");
    conv_even_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_07
        ROUND_ACCUMULATOR_OP && !ROUNDING_KIND_SELECT &&
        ((src & ((56'h2 << round_pos) - 56'h1)) == (56'h1 << round_pos)) |-> !rounded[round_pos + 6'h1])
        else $error("convergent tie not even");
    // rotate checks compare against the source word one edge back
    rol_carry_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_09
        ROTATE_LEFT_OP && !ROUND_ACCUMULATOR_OP && !CARRY_LOAD && !DEST_SEL_B && !ACC_LOAD_A
        |=> FLAG_C == $past(src[47]) && ACC_A[24] == $past(FLAG_C) && ACC_A[23:0] == $past(src[23:0]))
        else $error("rotate left wrong");
    rol_carry_b_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_09
        ROTATE_LEFT_OP && !ROUND_ACCUMULATOR_OP && DEST_SEL_B
        |=> FLAG_C == $past(src[47]) && ACC_B[24] == $past(FLAG_C) && ACC_B[47:25] == $past(src[46:24]))
        else $error("rotate left of B wrong");
    rol_keep_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_09
        ROTATE_LEFT_OP && !ROUND_ACCUMULATOR_OP && !DEST_SEL_B
        |=> ACC_A[47:25] == $past(src[46:24]) && ACC_A[55:48] == $past(src[55:48]))
        else $error("rotate left moved wrong bits");
    ror_carry_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_10
        ROTATE_RIGHT_OP && !ROTATE_LEFT_OP && !ROUND_ACCUMULATOR_OP && !CARRY_LOAD && DEST_SEL_B && !ACC_LOAD_B
        |=> FLAG_C == $past(src[24]) && ACC_B[47] == $past(FLAG_C) && ACC_B[55:48] == $past(src[55:48]))
        else $error("rotate right wrong");
    ror_carry_on_a_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_10
        ROTATE_RIGHT_OP && !ROTATE_LEFT_OP && !ROUND_ACCUMULATOR_OP && !DEST_SEL_B
        |=> FLAG_C == $past(src[24]) && ACC_A[47] == $past(FLAG_C) && ACC_A[46:24] == $past(src[47:25]))
        else $error("rotate right of A wrong");
    ror_keep_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_10
        ROTATE_RIGHT_OP && !ROTATE_LEFT_OP && !ROUND_ACCUMULATOR_OP && DEST_SEL_B
        |=> ACC_B[46:24] == $past(src[47:25]) && ACC_B[23:0] == $past(src[23:0]))
        else $error("rotate right moved wrong bits");
    rot_flags_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_11
        (ROTATE_LEFT_OP || ROTATE_RIGHT_OP) && !ROUND_ACCUMULATOR_OP
        |=> !FLAG_V && FLAG_N == ($past(DEST_SEL_B) ? ACC_B[47] : ACC_A[47]))
        else $error("rotate flags wrong");
    rot_zero_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_11
        (ROTATE_LEFT_OP || ROTATE_RIGHT_OP) && !ROUND_ACCUMULATOR_OP
        |=> FLAG_Z == (($past(DEST_SEL_B) ? ACC_B[47:24] : ACC_A[47:24]) == 24'h0))
        else $error("rotate zero flag wrong");
    rot_other_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_12
        (ROTATE_LEFT_OP || ROTATE_RIGHT_OP) && !ROUND_ACCUMULATOR_OP && !(DEST_SEL_B ? ACC_LOAD_A : ACC_LOAD_B)
        |=> ($past(DEST_SEL_B) ? ACC_A == $past(ACC_A) : ACC_B == $past(ACC_B)))
        else $error("rotate touched the other accumulator");
    round_dest_a_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_01
        ROUND_ACCUMULATOR_OP && !DEST_SEL_B |=> ACC_A == $past(rounded))
        else $error("round did not write A");
    round_other_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_12
        ROUND_ACCUMULATOR_OP && !(DEST_SEL_B ? ACC_LOAD_A : ACC_LOAD_B)
        |=> ($past(DEST_SEL_B) ? ACC_A == $past(ACC_A) : ACC_B == $past(ACC_B)))
        else $error("round touched the other accumulator");
    round_flags_keep_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_11
        ROUND_ACCUMULATOR_OP
        |=> $stable(FLAG_N) && $stable(FLAG_Z) && $stable(FLAG_V))
        else $error("round touched N Z V");
    pos_24_down_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_04
        !SIXTEEN_BIT_MODE && SCALE_SEL_LOW && !SCALE_SEL_HIGH |-> round_pos == 6'h18)
        else $error("wrong 24-bit down position");
    pos_16_none_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_05
        SIXTEEN_BIT_MODE && !SCALE_SEL_LOW |-> round_pos == (SCALE_SEL_HIGH ? 6'h1e : 6'h1f))
        else $error("wrong 16-bit position");
    conv_plain_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_07
        ROUND_ACCUMULATOR_OP && !ROUNDING_KIND_SELECT &&
        ((src & ((56'h2 << round_pos) - 56'h1)) != (56'h1 << round_pos))
        |-> rounded == ((src + (56'h1 << round_pos)) & ~((56'h2 << round_pos) - 56'h1)))
        else $error("convergent round off a tie differs from plain round");
    round_tie_twos_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_06
        ROUND_ACCUMULATOR_OP && ROUNDING_KIND_SELECT &&
        ((src & ((56'h2 << round_pos) - 56'h1)) == (56'h1 << round_pos))
        |-> rounded[round_pos + 6'h1] != src[round_pos + 6'h1])
        else $error("two's complement tie not rounded up");
    round_done_a: assert property (@(posedge CLK) disable iff (SRST) // RULE_01
        ROUND_ACCUMULATOR_OP |=> OP_DONE)
        else $error("round gave no done pulse");
    // no strobe, no pulse: a stale done would be read as a second op
    op_idle_done_a: assert property (@(posedge CLK) disable iff (SRST)
        !ROUND_ACCUMULATOR_OP && !ROTATE_LEFT_OP && !ROTATE_RIGHT_OP |=> !OP_DONE)
        else $error("done pulse without an op");
    // reset is synchronous, so the state is clean one edge after it is seen
    reset_clear_a: assert property (@(posedge CLK)
        SRST |=> ACC_A == arr_pkg::ACC_RESET && ACC_B == arr_pkg::ACC_RESET && !OP_DONE
        && !FLAG_N && !FLAG_Z && !FLAG_V && !FLAG_C)
        else $error("reset left state behind");

    // main scenarios the bench must reach
    round_seen_c: cover property (@(posedge CLK) ROUND_ACCUMULATOR_OP && !ROUNDING_KIND_SELECT);
    rol_seen_c: cover property (@(posedge CLK) ROTATE_LEFT_OP && FLAG_C);
    ror_zero_c: cover property (@(posedge CLK) ROTATE_RIGHT_OP ##1 FLAG_Z);
    round16_up_c: cover property (@(posedge CLK) ROUND_ACCUMULATOR_OP && SIXTEEN_BIT_MODE && SCALE_SEL_HIGH);
    back_to_back_c: cover property (@(posedge CLK) ROTATE_LEFT_OP ##1 ROTATE_RIGHT_OP);
endmodule

/* verilog/arr_round_unit.sv */
// combinational rounding of one 56-bit accumulator value
module arr_round_unit (
    input wire logic [55:0] value,
    input wire logic [1:0] scale_sel,
    input wire logic sixteen_bit,
    input wire logic convergent,
    output logic [55:0] rounded,
    output logic [5:0] round_pos
);
    logic [55:0] cst;
    logic [55:0] low_mask;
    logic [55:0] sum;
    always_comb begin
        // 11 falls through as no scaling
        unique case (scale_sel) // RULE_03 RULE_04 RULE_05
            arr_pkg::SCALE_DOWN: round_pos = sixteen_bit ? arr_pkg::POS16_DOWN : arr_pkg::POS24_DOWN;
            arr_pkg::SCALE_UP: round_pos = sixteen_bit ? arr_pkg::POS16_UP : arr_pkg::POS24_UP;
            default: round_pos = sixteen_bit ? arr_pkg::POS16_NONE : arr_pkg::POS24_NONE; // RULE_12
        endcase
        cst = 56'h1 << round_pos; // RULE_06
        low_mask = (cst << 1) - 56'h1;
        sum = value + cst;
        rounded = sum;
        if (convergent && ((sum & low_mask) == 56'h0)) begin // RULE_07
            rounded = sum & ~(cst << 1);
        end
        rounded = rounded & ~low_mask; // RULE_08
    end
endmodule
